/* hw/lf_out_pkg.sv */
/*
  shared constants for the low-frequency output select block and its spi link.
  assumes a single 200 MHz system clock on both ends.
*/
package lf_out_pkg;
  // system clock period
  localparam int CLK_NS = 5;
  // spi frame layout, msb first
  localparam int FRAME_BITS = 16;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 13;
  localparam int ADDR_MSB = 12;
  localparam int ADDR_LSB = 9;
  localparam int DUMMY_BITS = 7;
  // commands
  localparam logic [2:0] CMD_READ = 3'h6;
  localparam logic [2:0] CMD_WRITE = 3'h7;
  // register indexes and field positions
  localparam int NUM_CFG = 7;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam int CFG0_IDX = 0;
  localparam int CFG1_IDX = 1;
  localparam int CFG2_IDX = 2;
  localparam int CHAN_EN_BIT = 1;
  localparam int SEL_MSB = 8;
  localparam int SEL_LSB = 7;
  localparam int DIV_SEL_BIT = 7;
  localparam int DISCHARGE_BIT = 8;
  localparam logic [8:0] CFG_RESET = 9'h000;
  // output select codes
  localparam logic [1:0] SEL_DEMOD = 2'h0;
  localparam logic [1:0] SEL_CARRIER = 2'h1;
  // link timing: sclk half period and chip-select-high gap
  localparam int SCLK_HALF_NS = 80;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CSH_NS = 500;
  localparam int CSH_CYC = (CSH_NS + CLK_NS - 1) / CLK_NS;
  // host sequencer states
  typedef enum logic [2:0] {H_IDLE, H_PRE, H_LOW, H_HIGH, H_END, H_GAP} host_state_t;
endpackage

/* hw/lf_link_if.sv */
/*
  three-wire link between the microcontroller end and the device end.
  assumes the bench joins both ends; this interface resolves pin levels.
*/
`timescale 1ns/1ps
`default_nettype none
interface lf_link_if;
  // host drives
  logic host_cs_n;
  logic host_sclk_o;
  logic host_sclk_oe;
  logic host_sdio_o;
  logic host_sdio_oe;
  // device drives
  logic dev_alert_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  // resolved wire levels; sclk/alert has a pull-up, open drain pulls low
  logic cs_n;
  logic sclk;
  logic sdio;
  assign cs_n = host_cs_n;
  assign sclk = host_sclk_oe ? host_sclk_o : ~dev_alert_oe;
  assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b0);
  modport dev (input cs_n, input sclk, input sdio, output dev_alert_oe, output dev_sdio_o, output dev_sdio_oe);
  modport host (input sclk, input sdio, output host_cs_n, output host_sclk_o, output host_sclk_oe,
                output host_sdio_o, output host_sdio_oe);
endinterface
`default_nettype wire

/* hw/lf_out_dev.sv */
/*
  device end: configuration registers over the three-wire spi port and the
  selection of what drives the shared output pin.
  assumes link pins arrive asynchronously and are filtered here; front-end
  signals arrive on the user side.
*/
// Operation
// R01 - output only while channel enable set
// R02 - select field picks demod, carrier, strength
// R03 - cleared configuration selects demodulated data
// R04 - carrier output starts after agc settling
// R05 - divide bit: carrier by one or four
// R06 - same qualification for carrier and data
// R07 - strength mode disables all timers
// R08 - strength mode forces active mode
// R09 - strength mode suspended during spi transaction
// R10 - strength persists; off while select low
// R11 - discharge pull-down only in strength mode
// R12 - spi reads, writes and command frames
// R13 - chip select always an input
// R14 - alert open drain high, clock low
// R15 - data pin output, input or readback
// R16 - host holds clock low before select
// R17 - host sends read frame, then releases
// R18 - result: seven dummies, data, parity
// R19 - host raises select, releases clock
// R20 - data begins eighth clock after gap
// R21 - mode 0: sample rise, shift fall
// R22 - non-multiple of sixteen clocks aborts
// R23 - command, address, data, parity, msb first
// R24 - divide counter cleared entering carrier mode
`timescale 1ns/1ps
`default_nettype none
module lf_out_dev #(
  parameter int FRAME_LEN = lf_out_pkg::FRAME_BITS
) (
  // system
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  // link
  lf_link_if.dev link,
  // front end
  input wire logic demod_in,
  input wire logic carrier_in,
  input wire logic agc_settled,
  input wire logic qualify_ok,
  input wire logic alert_req,
  // control towards front end
  output logic rssi_on,
  output logic discharge_on,
  output logic timers_off,
  output logic force_active,
  output logic cmd_strobe,
  output logic [2:0] cmd_code
);
  if (FRAME_LEN != 16) begin : g_len_chk
    $error("frame length must be sixteen");
  end

  // synchroniser stages: {carrier, sdio, sclk, cs_n}
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] filt_r;
  logic [3:0] filt_nxt;
  logic [8:0] cfg_r [0:lf_out_pkg::NUM_CFG-1];
  logic [15:0] shin_r;
  logic [15:0] shout_r;
  logic [3:0] bit_cnt_r;
  logic have_frame_r;
  logic out_mode_r;
  logic rd_pend_r;
  logic [3:0] rd_addr_r;
  logic [1:0] div_r;
  logic sdio_o_r;
  logic sdio_oe_r;
  logic alert_oe_r;

  // a change counts only once stages two and three agree
  assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));

  wire cs_high = filt_r[0];
  wire cs_fall = filt_r[0] & ~filt_nxt[0];
  wire cs_rise = ~filt_r[0] & filt_nxt[0];
  wire sclk_rise = ~filt_r[0] & ~filt_r[1] & filt_nxt[1];
  wire sclk_fall = ~filt_r[0] & filt_r[1] & ~filt_nxt[1];
  wire car_rise = ~filt_r[3] & filt_nxt[3];

  // decode of the held frame
  wire [2:0] f_cmd = shin_r[lf_out_pkg::CMD_MSB:lf_out_pkg::CMD_LSB];
  wire [3:0] f_addr = shin_r[lf_out_pkg::ADDR_MSB:lf_out_pkg::ADDR_LSB];
  wire frame_ok = have_frame_r & (bit_cnt_r == 4'h0) & ~out_mode_r; // see R22
  wire do_write = cs_rise & frame_ok & (f_cmd == lf_out_pkg::CMD_WRITE) & (f_addr < lf_out_pkg::ADDR_STATUS);
  wire do_read = cs_rise & frame_ok & (f_cmd == lf_out_pkg::CMD_READ);
  wire do_cmd = cs_rise & frame_ok & (f_cmd < lf_out_pkg::CMD_READ); // see R12

  // mode decode; a cleared select field means demodulated data
  wire [1:0] sel = cfg_r[lf_out_pkg::CFG1_IDX][lf_out_pkg::SEL_MSB:lf_out_pkg::SEL_LSB]; // see R02
  wire is_rssi = sel[1]; // see R02
  wire is_carrier = (sel == lf_out_pkg::SEL_CARRIER); // see R03
  wire chan_en = cfg_r[lf_out_pkg::CFG0_IDX][lf_out_pkg::CHAN_EN_BIT];
  wire div4 = cfg_r[lf_out_pkg::CFG2_IDX][lf_out_pkg::DIV_SEL_BIT];

  // status word: strength mode and alert request, parity bit reads zero
  wire [8:0] status = {6'h00, is_rssi, alert_req, 1'b0};
  // addresses above the status word read status too, so no index runs past the array
  wire [8:0] rd_word = (rd_addr_r >= lf_out_pkg::ADDR_STATUS) ? status : cfg_r[rd_addr_r[2:0]];

  // carrier squared, optionally divided by four, gated by agc settling
  wire car_sq = div4 ? div_r[1] : filt_r[3]; // see R05
  wire car_bit = car_sq & agc_settled; // see R04
  wire data_bit = (is_carrier ? car_bit : demod_in) & qualify_ok; // see R06

  // pin drive: digital output only while select high and channel enabled
  wire sdio_oe_nxt = cs_high ? (chan_en & ~is_rssi) : out_mode_r; // see R01 R15
  wire sdio_o_nxt = cs_high ? data_bit : shout_r[15]; // see R15
  wire alert_oe_nxt = cs_high & alert_req; // see R14

  // input filtering; s1 feeds s2 alone
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 4'h3;
      s2_r <= 4'h3;
      s3_r <= 4'h3;
      filt_r <= 4'h3;
    end else if (ce) begin
      s1_r <= {carrier_in, link.sdio, link.sclk, link.cs_n}; // see R13
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  // serial shifter and frame counter
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shin_r <= 16'h0000;
      shout_r <= 16'h0000;
      bit_cnt_r <= 4'h0;
      have_frame_r <= 1'b0;
      out_mode_r <= 1'b0;
    end else if (ce) begin
      if (cs_fall) begin
        bit_cnt_r <= 4'h0;
        have_frame_r <= 1'b0;
        out_mode_r <= rd_pend_r; // see R15
        shout_r <= {7'h00, rd_word}; // see R18 R20
      end else if (cs_rise) begin
        out_mode_r <= 1'b0;
      end else if (sclk_rise) begin
        shin_r <= {shin_r[14:0], filt_r[2]}; // see R21 R23
        bit_cnt_r <= bit_cnt_r + 4'h1;
        if (bit_cnt_r == 4'hf) begin
          have_frame_r <= 1'b1;
        end
      end else if (sclk_fall && out_mode_r) begin
        shout_r <= {shout_r[14:0], 1'b0}; // see R21
      end
    end
  end

  // configuration write and read bookkeeping
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < lf_out_pkg::NUM_CFG; i++) begin
        cfg_r[i] <= lf_out_pkg::CFG_RESET; // see R03
      end
      rd_pend_r <= 1'b0;
      rd_addr_r <= 4'h0;
    end else if (ce) begin
      if (do_write) begin
        cfg_r[f_addr[2:0]] <= shin_r[8:0]; // see R12
      end
      // an aborted or finished frame also drops a pending readback
      if (cs_rise) begin
        rd_pend_r <= do_read; // see R22
        if (do_read) begin
          rd_addr_r <= f_addr;
        end
      end
    end
  end

  // two-bit carrier divider, cleared outside carrier mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= 2'h0;
    end else if (ce) begin
      if (!is_carrier) begin
        div_r <= 2'h0; // see R24
      end else if (car_rise) begin
        div_r <= div_r + 2'h1; // see R24
      end
    end
  end

  // registered pin and front-end controls
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sdio_o_r <= 1'b0;
      sdio_oe_r <= 1'b0;
      alert_oe_r <= 1'b0;
      rssi_on <= 1'b0;
      discharge_on <= 1'b0;
      timers_off <= 1'b0;
      force_active <= 1'b0;
      cmd_strobe <= 1'b0;
      cmd_code <= 3'h0;
    end else if (ce) begin
      sdio_o_r <= sdio_o_nxt;
      sdio_oe_r <= sdio_oe_nxt;
      alert_oe_r <= alert_oe_nxt;
      rssi_on <= is_rssi & chan_en & cs_high; // see R09 R10
      discharge_on <= is_rssi & cfg_r[lf_out_pkg::CFG2_IDX][lf_out_pkg::DISCHARGE_BIT]; // see R11
      timers_off <= is_rssi; // see R07
      force_active <= is_rssi; // see R08
      cmd_strobe <= do_cmd;
      if (do_cmd) begin
        cmd_code <= f_cmd;
      end
    end
  end

  // pins driven from flops so nothing glitches on the shared wire
  assign link.dev_sdio_o = sdio_o_r;
  assign link.dev_sdio_oe = sdio_oe_r;
  assign link.dev_alert_oe = alert_oe_r;
endmodule
`default_nettype wire

/* hw/lf_out_host.sv */
/*
  microcontroller end: runs write, command and two-frame read sequences.
  assumes the device filters the link in a few cycles, well inside a half period.
*/
`timescale 1ns/1ps
`default_nettype none
module lf_out_host #(
  parameter int HALF_CYC = lf_out_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC = lf_out_pkg::CSH_CYC
) (
  // system
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ce,
  // link
  lf_link_if.host link,
  // user request
  input wire logic start,
  input wire logic [2:0] cmd,
  input wire logic [3:0] addr,
  input wire logic [8:0] data,
  // user answer
  output logic busy,
  output logic rd_valid,
  output logic [8:0] rd_word,
  output logic alert_seen
);
  // readback crosses the device filter, two output flops and our own filter, about ten cycles,
  // so a shorter half period would sample the previous bit
  if (HALF_CYC < 10 || HALF_CYC > 255 || GAP_CYC < 1 || GAP_CYC > 255) begin : g_time_chk
    $error("link timing out of range");
  end

  lf_out_pkg::host_state_t st_r;
  logic [7:0] tmr_r;
  logic [3:0] bits_r;
  logic [15:0] sh_r;
  logic [15:0] rx_r;
  logic is_rd_r;
  logic second_r;
  logic [2:0] sclk_s_r;
  logic sclk_f_r;
  logic [2:0] sdio_s_r;
  logic sdio_f_r;

  wire tmr_done = (tmr_r == 8'h00);
  wire [7:0] half = 8'(HALF_CYC - 1);
  wire [7:0] gap = 8'(GAP_CYC - 1);
  assign busy = (st_r != lf_out_pkg::H_IDLE);

  // readback and alert pin filters, second and third stages must agree
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sdio_s_r <= 3'h0;
      sdio_f_r <= 1'b0;
      sclk_s_r <= 3'h7;
      sclk_f_r <= 1'b1;
      alert_seen <= 1'b0;
    end else if (ce) begin
      sdio_s_r <= {sdio_s_r[1:0], link.sdio};
      if (sdio_s_r[1] == sdio_s_r[2]) begin
        sdio_f_r <= sdio_s_r[2];
      end
      sclk_s_r <= {sclk_s_r[1:0], link.sclk};
      if (sclk_s_r[1] == sclk_s_r[2]) begin
        sclk_f_r <= sclk_s_r[2];
      end
      alert_seen <= ~busy & ~sclk_f_r; // see R14
    end
  end

  // transfer sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= lf_out_pkg::H_IDLE;
      tmr_r <= 8'h00;
      bits_r <= 4'h0;
      sh_r <= 16'h0000;
      rx_r <= 16'h0000;
      is_rd_r <= 1'b0;
      second_r <= 1'b0;
      rd_valid <= 1'b0;
      rd_word <= 9'h000;
      link.host_cs_n <= 1'b1;
      link.host_sclk_o <= 1'b0;
      link.host_sclk_oe <= 1'b0;
      link.host_sdio_o <= 1'b0;
      link.host_sdio_oe <= 1'b0;
    end else if (ce) begin
      rd_valid <= 1'b0;
      if (!tmr_done) begin
        tmr_r <= tmr_r - 8'h01;
      end
      unique case (st_r)
        lf_out_pkg::H_IDLE: begin
          if (start) begin
            sh_r <= {cmd, addr, data};
            is_rd_r <= (cmd == lf_out_pkg::CMD_READ);
            second_r <= 1'b0;
            link.host_sclk_oe <= 1'b1; // see R16
            tmr_r <= half;
            st_r <= lf_out_pkg::H_PRE;
          end
        end
        lf_out_pkg::H_PRE: begin
          if (tmr_done) begin
            link.host_cs_n <= 1'b0;
            link.host_sdio_oe <= 1'b1;
            link.host_sdio_o <= sh_r[15];
            bits_r <= 4'h0;
            tmr_r <= half;
            st_r <= lf_out_pkg::H_LOW;
          end
        end
        lf_out_pkg::H_LOW: begin
          if (tmr_done) begin
            link.host_sclk_o <= 1'b1; // see R21
            rx_r <= {rx_r[14:0], sdio_f_r};
            tmr_r <= half;
            st_r <= lf_out_pkg::H_HIGH;
          end
        end
        lf_out_pkg::H_HIGH: begin
          if (tmr_done) begin
            link.host_sclk_o <= 1'b0;
            bits_r <= bits_r + 4'h1;
            sh_r <= {sh_r[14:0], 1'b0};
            link.host_sdio_o <= sh_r[14];
            tmr_r <= half;
            st_r <= (bits_r == 4'hf) ? lf_out_pkg::H_END : lf_out_pkg::H_LOW;
          end
        end
        lf_out_pkg::H_END: begin
          if (tmr_done) begin
            link.host_cs_n <= 1'b1;
            link.host_sdio_oe <= 1'b0; // see R17
            if (is_rd_r && !second_r) begin
              second_r <= 1'b1;
              tmr_r <= gap;
              st_r <= lf_out_pkg::H_GAP;
            end else begin
              link.host_sclk_oe <= 1'b0; // see R19
              rd_valid <= second_r;
              rd_word <= rx_r[8:0]; // see R18
              st_r <= lf_out_pkg::H_IDLE;
            end
          end
        end
        lf_out_pkg::H_GAP: begin
          if (tmr_done) begin
            link.host_cs_n <= 1'b0; // see R20
            bits_r <= 4'h0;
            tmr_r <= half;
            st_r <= lf_out_pkg::H_LOW;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* verif/lf_link_monitor.sv */
/*
  checker on the three-wire link between the two ends.
  assumes the bench feeds it the interface signals and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lf_link_monitor (
  // system
  input wire logic clock,
  input wire logic arst_n,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_sclk_oe,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_alert_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [3:0] rises_r;
  // rising clocks in one select-low period, kept modulo a frame
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      rises_r <= 4'h0;
    else if (cs_n)
      rises_r <= 4'h0;
    else if ($rose(sclk))
      rises_r <= rises_r + 4'h1;
  end
  a_alert_select_low: assert property (!cs_n [*6] |-> !dev_alert_oe) else $error("alert driven in frame");
  a_clock_low_fall: assert property ($fell(cs_n) |-> !sclk && host_sclk_oe) else $error("clock not low");
  a_clock_driven: assert property (!cs_n |-> host_sclk_oe) else $error("clock released in frame");
  a_rise_in_frame: assert property ($rose(sclk) && host_sclk_oe |-> !cs_n) else $error("clock outside frame");
  a_host_data_low: assert property (host_sdio_oe && $changed(host_sdio_o) |-> !sclk) else $error("host data moved");
  a_dev_data_fall: assert property (dev_sdio_oe && !cs_n && $changed(dev_sdio_o) |-> !sclk)
    else $error("device data moved");
  a_frame_multiple: assert property ($rose(cs_n) |-> rises_r == 4'h0) else $error("partial frame");
  a_gap_held: assert property ($rose(cs_n) |-> cs_n [*4]) else $error("gap too short");
  a_no_fight: assert property ((!cs_n [*6]) ##0 dev_sdio_oe |-> !host_sdio_oe) else $error("data contention");
endmodule
`default_nettype wire

/* verif/test_lf_output_select_spi_port.sv */
/*
  self-checking bench joining host and device ends over the link.
  assumes a short select gap and the default half period; front end is driven directly.
*/
`timescale 1ns/1ps
`default_nettype none
module test_lf_output_select_spi_port;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic [3:0] addr = 4'h0;
  logic [8:0] data = 9'h000;
  logic demod_in = 1'b0;
  logic carrier_in = 1'b0;
  logic agc_settled = 1'b0;
  logic qualify_ok = 1'b1;
  logic alert_req = 1'b0;
  logic busy, rd_valid, alert_seen, rssi_on, discharge_on, timers_off, force_active, cmd_strobe;
  logic [8:0] rd_word;
  logic [2:0] cmd_code;
  logic [31:0] seed = 32'h549c146a;
  logic [8:0] shadow [0:6];
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int strobes = 0;
  int valids = 0;

  always #2.5 clock = ~clock;

  lf_link_if lf_link_if_i ();
  lf_out_dev lf_out_dev_i (.clock(clock), .arst_n(arst_n), .ce(1'b1), .link(lf_link_if_i), .demod_in(demod_in),
    .carrier_in(carrier_in), .agc_settled(agc_settled), .qualify_ok(qualify_ok), .alert_req(alert_req),
    .rssi_on(rssi_on), .discharge_on(discharge_on), .timers_off(timers_off), .force_active(force_active),
    .cmd_strobe(cmd_strobe), .cmd_code(cmd_code));
  // short gap keeps the run brief; the half period must cover the readback latency
  lf_out_host #(.HALF_CYC(16), .GAP_CYC(4)) lf_out_host_i (.clock(clock), .arst_n(arst_n), .ce(1'b1),
    .link(lf_link_if_i), .start(start), .cmd(cmd), .addr(addr), .data(data), .busy(busy), .rd_valid(rd_valid),
    .rd_word(rd_word), .alert_seen(alert_seen));
  lf_link_monitor lf_link_monitor_i (.clock(clock), .arst_n(arst_n), .cs_n(lf_link_if_i.cs_n),
    .sclk(lf_link_if_i.sclk), .host_sclk_oe(lf_link_if_i.host_sclk_oe), .host_sdio_o(lf_link_if_i.host_sdio_o),
    .host_sdio_oe(lf_link_if_i.host_sdio_oe), .dev_alert_oe(lf_link_if_i.dev_alert_oe),
    .dev_sdio_o(lf_link_if_i.dev_sdio_o), .dev_sdio_oe(lf_link_if_i.dev_sdio_oe));

  // cycle ceiling and command pulse count
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cmd_strobe === 1'b1)
      strobes <= strobes + 1;
    if (rd_valid === 1'b1)
      valids <= valids + 1;
    if (cycles == 60000) begin
      n_errors++;
      final_report();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // odd row parity over the byte
  function automatic logic [8:0] word(input logic [7:0] b);
    return {b, ~^b};
  endfunction

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one host transfer; mid looks at strength output while select is low
  task automatic xfer(input logic [2:0] c, input logic [3:0] a, input logic [8:0] d, input bit mid);
    int k;
    @(posedge clock);
    start <= 1'b1;
    cmd <= c;
    addr <= a;
    data <= d;
    @(posedge clock);
    start <= 1'b0;
    // one more edge so busy is seen raised before waiting on it
    @(posedge clock);
    k = 0;
    while (mid && lf_link_if_i.cs_n !== 1'b0 && k < 2000) begin
      @(posedge clock);
      k++;
    end
    if (mid) begin
      repeat (8) @(posedge clock);
      check(rssi_on, 9'h000);
    end
    while (busy !== 1'b0 && k < 20000) begin
      @(posedge clock);
      k++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] b);
    shadow[a] = word(b);
    xfer(lf_out_pkg::CMD_WRITE, a, word(b), 0);
  endtask

  task automatic rd(input logic [3:0] a, input logic [8:0] exp);
    int v;
    v = valids;
    xfer(lf_out_pkg::CMD_READ, a, 9'h000, 0);
    @(posedge clock);
    check(rd_word, exp);
    check(9'(valids - v), 9'h001);
  endtask

  task automatic settle();
    repeat (10) @(posedge clock);
  endtask

  // toggles the carrier n periods and counts rises at the pin
  task automatic carrier(input int n, input int exp);
    int r;
    logic p;
    r = 0;
    p = lf_link_if_i.sdio;
    for (int i = 0; i < n * 8 + 8; i++) begin
      @(posedge clock);
      carrier_in <= (i % 8 >= 4) && (i < n * 8);
      if (lf_link_if_i.sdio === 1'b1 && p === 1'b0)
        r++;
      p = lf_link_if_i.sdio;
    end
    check(r[8:0], exp[8:0]);
  endtask

  initial begin
    logic [31:0] r;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    settle();
    check(lf_link_if_i.dev_sdio_oe, 9'h000);
    rd(4'h1, 9'h000);
    // random contents written to every register but index 3, then read back
    for (int a = 0; a < 7; a++) begin
      r = xs();
      if (a != 3)
        wr(a[3:0], r[7:0]);
    end
    for (int a = 0; a < 7; a++)
      if (a != 3)
        rd(a[3:0], shadow[a]);
    // every select code with the channel on and pull-down requested
    for (int s = 0; s < 4; s++) begin
      r = xs();
      demod_in <= r[0];
      wr(4'h0, 8'h01);
      wr(4'h2, 8'h80);
      wr(4'h1, {s[1:0], 6'h00});
      settle();
      check(lf_link_if_i.dev_sdio_oe, {8'h00, ~s[1]});
      check(rssi_on, {8'h00, s[1]});
      check(discharge_on, {8'h00, s[1]});
      check(timers_off, {8'h00, s[1]});
      check(force_active, {8'h00, s[1]});
      if (s == 0)
        check(lf_link_if_i.sdio, {8'h00, r[0]});
    end
    xfer(lf_out_pkg::CMD_READ, 4'h0, 9'h000, 1);
    settle();
    check(rssi_on, 9'h001);
    xfer(lf_out_pkg::CMD_WRITE, 4'h7, 9'h1ff, 0);
    rd(4'h7, 9'h004);
    alert_req <= 1'b1;
    settle();
    check(alert_seen, 9'h001);
    rd(4'h7, 9'h006);
    alert_req <= 1'b0;
    settle();
    check(alert_seen, 9'h000);
    // carrier output: divider cleared on entry, then undivided and gated
    agc_settled <= 1'b1;
    wr(4'h2, 8'h40);
    wr(4'h1, 8'h40);
    carrier(8, 2);
    wr(4'h2, 8'h00);
    carrier(4, 4);
    qualify_ok <= 1'b0;
    carrier(4, 0);
    qualify_ok <= 1'b1;
    agc_settled <= 1'b0;
    carrier(4, 0);
    // command-only codes, each one pulse
    for (int c = 0; c < 6; c++) begin
      r = xs();
      xfer(c[2:0], r[3:0], r[12:4], 0);
      settle();
      check(cmd_code, c[8:0]);
      check(strobes[8:0], c[8:0] + 9'h001);
    end
    final_report();
  end
endmodule
`default_nettype wire
